// ---- core/dhl_defines.svh ----
// Offsets, field positions, reset values and fixed-point constants of the headroom limiter
`ifndef DHL_DEFINES_SVH
`define DHL_DEFINES_SVH

// Register byte offsets
`define DHL_CTRL_OFS    32'h0000_0000
`define DHL_CFG_OFS     32'h0000_0004
`define DHL_STAT_OFS    32'h0000_0008
`define DHL_LEVEL_OFS   32'h0000_000C

// Control fields
`define DHL_CTRL_EN     0
`define DHL_CTRL_KIND   1

// Configuration fields
`define DHL_CFG_GAIN    0
`define DHL_CFG_HR      4
`define DHL_CFG_ROT     9
`define DHL_CFG_THR     13

// Reset values
`define DHL_CTRL_RST    2'h0
`define DHL_CFG_RST     17'h0_0000

// Word size of a supported bus access
`define DHL_HSIZE_WORD  3'h2

// Gain code cap (16dB) and dB offset of code 0
`define DHL_GAIN_CAP    4'hC
`define DHL_GAIN_BASE   5'h04

// Headroom code limit: 8 steps of 2.5%, 40 steps make 100%
`define DHL_HR_MAX      5'h08
`define DHL_HR_FULL     6'h28

// Levels are log2 in 1/256 octave units
`define DHL_LOG2_40     16'h0552
`define DHL_VOLT_SHIFT  16'h0800
`define DHL_MPO_BASE    16'h009D
`define DHL_IN_FS       16'h1700
`define DHL_FLOOR       16'hF000
`define DHL_DB_MUL      16'h00AA
`define DHL_DB_SHIFT    2
`define DHL_UNITY       17'h0_8000

`endif

// ---- core/dhl_pkg.sv ----
// Shared types of the headroom limiter
package dhl_pkg;

  // Level or attenuation, log2 with 8 fraction bits
  typedef logic signed [15:0] dhl_lvl_t;

  // Audio sample, two's complement
  typedef logic signed [23:0] dhl_smp_t;

  // Unsigned log2 result, 5 integer and 8 fraction bits
  typedef logic [12:0] dhl_log_t;

  // Linear gain, 2.15 fixed point
  typedef logic [16:0] dhl_gain_t;

endpackage

// ---- core/dhl_log2.sv ----
// Piecewise-linear base-2 logarithm of an unsigned magnitude
module dhl_log2
(
  // Magnitude
  input  wire logic [23:0]       value,
  // Result
  output dhl_pkg::dhl_log_t      log_q8,
  output logic                   is_zero
);

  logic [4:0]  msb;
  logic [23:0] norm;

  always_comb
  begin
    msb = 5'h00;
    for (int i = 0; i < 24; i++)
    begin
      if (value[i])
      begin
        msb = 5'(i);
      end
    end
    norm = value << (5'd23 - msb);
  end

  // Leading-one position plus mantissa fraction
  assign log_q8  = {msb, norm[22:15]};
  assign is_zero = (value == 24'h00_0000);

endmodule

// ---- core/dhl_exp2.sv ----
// Converts a non-positive log2 attenuation into a linear gain
`include "dhl_defines.svh"
module dhl_exp2
(
  // Attenuation, at most zero
  input  dhl_pkg::dhl_lvl_t  att_q8,
  // Gain, at most unity
  output dhl_pkg::dhl_gain_t gain_q15
);

  logic signed [7:0] int_part;
  logic [7:0]        shift;
  logic [16:0]       mant;

  always_comb
  begin
    int_part = att_q8[15:8];
    shift    = 8'(-int_part);
    mant     = `DHL_UNITY + {2'b00, att_q8[7:0], 7'h00};
    // Mantissa is below two, so any shift of one or more stays below unity
    if (att_q8 >= 16'sh0000)
    begin
      gain_q15 = `DHL_UNITY;
    end
    else if (shift > 8'h10)
    begin
      gain_q15 = 17'h0_0000;
    end
    else
    begin
      gain_q15 = mant >> shift;
    end
  end

endmodule

// ---- core/dhl_top.sv ----
// Headroom limiter with supply tracking, fixed limiter, compressor and AHB-Lite registers
`include "dhl_defines.svh"

module dhl_top
(
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Supply measurements
  input  wire logic [15:0]       power_rail_level,
  input  wire logic [15:0]       battery_rail_level,
  input  wire logic              rail_is_power,
  // Audio in
  input  dhl_pkg::dhl_smp_t      sample_in,
  input  wire logic              sample_in_valid,
  // Audio out
  output dhl_pkg::dhl_smp_t      sample_out,
  output logic                   sample_out_valid,
  // Events and status
  output logic                   attenuation_begin_event,
  output logic                   attenuation_end_event,
  output logic                   headroom_active
);

  typedef struct packed {
    // Control and configuration
    logic                        headroom_track_enable;
    logic                        limiter_kind_select;
    logic [3:0]                  full_scale_output_scale;
    logic [4:0]                  supply_headroom_pct;
    logic [3:0]                  compressor_rotation_point;
    logic [3:0]                  fixed_limiter_threshold;
    // Bus state
    logic                        wr_pend;
    logic [31:0]                 wr_addr;
    logic [31:0]                 rdata;
    logic                        ready;
    logic                        resp;
    // Limiter state
    dhl_pkg::dhl_lvl_t           atpo;
    dhl_pkg::dhl_lvl_t           ain;
    dhl_pkg::dhl_lvl_t           atten;
    logic                        active;
    logic                        begin_ev;
    logic                        end_ev;
    // Output stream
    dhl_pkg::dhl_smp_t           sample;
    logic                        valid;
  } dhl_state_s;

  dhl_state_s                    r;
  dhl_state_s                    next_r;

  // dB code to log2 units: 1dB is about 0.1661 octave
  function automatic dhl_pkg::dhl_lvl_t db_to_lvl(input logic [4:0] code);
    logic [15:0] prod;
    prod = 16'(code) * `DHL_DB_MUL;
    return dhl_pkg::dhl_lvl_t'(prod >> `DHL_DB_SHIFT);
  endfunction

  // Log2 result to a signed level, less an offset
  function automatic dhl_pkg::dhl_lvl_t log_to_lvl(input dhl_pkg::dhl_log_t lg, input dhl_pkg::dhl_lvl_t ofs);
    return dhl_pkg::dhl_lvl_t'({3'b000, lg}) - ofs;
  endfunction

  // Threshold code to level, one dB below full scale per step
  function automatic dhl_pkg::dhl_lvl_t fs_below(input logic [3:0] code);
    return -db_to_lvl(5'(code));
  endfunction

  // Any negative attenuation counts as limiting
  function automatic logic is_cut(input dhl_pkg::dhl_lvl_t a);
    return a < 16'sh0000;
  endfunction

  // Supply and target peak
  logic [15:0]                   sup;
  logic signed [5:0]             hr_code;
  logic [5:0]                    hr_fac;
  logic [23:0]                   vtpo40;
  dhl_pkg::dhl_log_t             l_sup;
  logic                          sup_zero;
  logic [3:0]                    gain_code;
  dhl_pkg::dhl_lvl_t             lvl_vtpo;
  dhl_pkg::dhl_lvl_t             lvl_vmpo;
  dhl_pkg::dhl_lvl_t             atpo_raw;

  // Input level and attenuation
  logic [23:0]                   mag;
  dhl_pkg::dhl_log_t             l_in;
  logic                          in_zero;
  dhl_pkg::dhl_lvl_t             ain;
  dhl_pkg::dhl_lvl_t             drc_rp;
  dhl_pkg::dhl_lvl_t             drc_att;
  dhl_pkg::dhl_lvl_t             lim_rp;
  dhl_pkg::dhl_lvl_t             lvl_post;
  dhl_pkg::dhl_lvl_t             lim_att;
  dhl_pkg::dhl_lvl_t             att;
  dhl_pkg::dhl_gain_t            gain;
  logic signed [41:0]            prod;
  logic                          addr_phase;

  always_comb
  begin
    // Rail that currently powers the amplifier
    sup = rail_is_power ? power_rail_level : battery_rail_level;

    // Headroom code, 2.5% per step, held inside +-20%
    hr_code = 6'(signed'(r.supply_headroom_pct));
    if (hr_code > 6'sd8)
    begin
      hr_code = 6'(`DHL_HR_MAX);
    end
    else if (hr_code < -6'sd8)
    begin
      hr_code = -6'(`DHL_HR_MAX);
    end
    hr_fac = `DHL_HR_FULL - 6'(hr_code);
    vtpo40 = 24'(sup * hr_fac);
  end

  dhl_log2 u_log_sup
  (
    .value                       (vtpo40),
    .log_q8                      (l_sup),
    .is_zero                     (sup_zero)
  );

  always_comb
  begin
    // Supply in 8.8 volts, product carries a factor of 40
    lvl_vtpo = log_to_lvl(l_sup, `DHL_VOLT_SHIFT + `DHL_LOG2_40);

    // Peak output level, gain above 16dB not counted
    gain_code = (r.full_scale_output_scale > `DHL_GAIN_CAP) ? `DHL_GAIN_CAP
                                                             : r.full_scale_output_scale;
    lvl_vmpo = `DHL_MPO_BASE + db_to_lvl(5'(gain_code) + `DHL_GAIN_BASE);

    atpo_raw = lvl_vtpo - lvl_vmpo;
    if (sup_zero)
    begin
      atpo_raw = `DHL_FLOOR;
    end
    else if (atpo_raw > 16'sh0000)
    begin
      atpo_raw = 16'sh0000;
    end
  end

  // Input magnitude; most negative sample maps to full scale
  assign mag = sample_in[23] ? 24'(-sample_in) : 24'(sample_in);

  dhl_log2 u_log_in
  (
    .value                       (mag),
    .log_q8                      (l_in),
    .is_zero                     (in_zero)
  );

  always_comb
  begin
    // Input level relative to full scale
    ain = in_zero ? `DHL_FLOOR
                  : log_to_lvl(l_in, `DHL_IN_FS);

    // Compressor, 2:1 above its rotation point, off at 0dBFS
    drc_rp  = fs_below(r.compressor_rotation_point);
    drc_att = 16'sh0000;
    if (r.compressor_rotation_point != 4'h0 && ain > drc_rp)
    begin
      drc_att = (drc_rp - ain) >>> 1;
    end

    // Limiter rotation: target peak when tracking, else fixed threshold
    if (r.limiter_kind_select)
    begin
      lim_rp = fs_below(r.fixed_limiter_threshold);
    end
    else
    begin
      lim_rp = r.atpo;
    end

    // Infinite-ratio limiter acts on the compressed level
    lvl_post = ain + drc_att;
    lim_att  = 16'sh0000;
    if (lvl_post > lim_rp)
    begin
      lim_att = lim_rp - lvl_post;
    end

    // Clearing enable mid-span releases at once and ends the span
    att = r.headroom_track_enable ? (drc_att + lim_att) : 16'sh0000;
  end

  dhl_exp2 u_exp
  (
    .att_q8                      (att),
    .gain_q15                    (gain)
  );

  // Fifteen fraction bits; unity gain returns the sample exactly
  assign prod       = 42'(sample_in * $signed({1'b0, gain}));
  // Transfer taken when selected, non-idle and bus ready
  assign addr_phase = hsel && htrans[1] && hready;

  always_comb
  begin
    next_r = r;

    // Target attenuation follows the supply every cycle
    next_r.atpo  = atpo_raw;
    next_r.ready = 1'b1;
    next_r.resp  = 1'b0;

    // Data phase of a write
    if (r.wr_pend)
    begin
      unique case (r.wr_addr)
        `DHL_CTRL_OFS:
        begin
          next_r.headroom_track_enable = hwdata[`DHL_CTRL_EN];
          next_r.limiter_kind_select   = hwdata[`DHL_CTRL_KIND];
        end
        `DHL_CFG_OFS:
        begin
          next_r.full_scale_output_scale   = hwdata[`DHL_CFG_GAIN +: 4];
          next_r.supply_headroom_pct       = hwdata[`DHL_CFG_HR +: 5];
          next_r.compressor_rotation_point = hwdata[`DHL_CFG_ROT +: 4];
          next_r.fixed_limiter_threshold   = hwdata[`DHL_CFG_THR +: 4];
        end
        default:
        begin
        end
      endcase
    end

    // Address phase; reads see a write still in its data phase
    next_r.wr_pend = 1'b0;
    if (addr_phase)
    begin
      next_r.wr_pend = hwrite && (hsize == `DHL_HSIZE_WORD);
      next_r.wr_addr = haddr;
      if (!hwrite)
      begin
        next_r.rdata = 32'h0000_0000;
        unique case (haddr)
          `DHL_CTRL_OFS:
          begin
            next_r.rdata[`DHL_CTRL_EN]   = next_r.headroom_track_enable;
            next_r.rdata[`DHL_CTRL_KIND] = next_r.limiter_kind_select;
          end
          `DHL_CFG_OFS:
          begin
            next_r.rdata[`DHL_CFG_GAIN +: 4] = next_r.full_scale_output_scale;
            next_r.rdata[`DHL_CFG_HR +: 5]   = next_r.supply_headroom_pct;
            next_r.rdata[`DHL_CFG_ROT +: 4]  = next_r.compressor_rotation_point;
            next_r.rdata[`DHL_CFG_THR +: 4]  = next_r.fixed_limiter_threshold;
          end
          `DHL_STAT_OFS:
          begin
            next_r.rdata = {r.atten, 15'h0000, r.active};
          end
          `DHL_LEVEL_OFS:
          begin
            next_r.rdata = {r.atpo, r.ain};
          end
          default:
          begin
          end
        endcase
      end
    end

    // One result per input sample
    next_r.valid    = 1'b0;
    next_r.begin_ev = 1'b0;
    next_r.end_ev   = 1'b0;
    if (sample_in_valid)
    begin
      next_r.valid    = 1'b1;
      next_r.sample   = prod[38:15];
      next_r.atten    = att;
      next_r.ain      = ain;
      next_r.active   = is_cut(att);
      // Events only at the edges of the active span
      next_r.begin_ev = !r.active && is_cut(att);
      next_r.end_ev   = r.active && !is_cut(att);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r.headroom_track_enable     <= 1'(`DHL_CTRL_RST >> `DHL_CTRL_EN);
      r.limiter_kind_select       <= 1'(`DHL_CTRL_RST >> `DHL_CTRL_KIND);
      r.full_scale_output_scale   <= 4'(`DHL_CFG_RST >> `DHL_CFG_GAIN);
      r.supply_headroom_pct       <= 5'(`DHL_CFG_RST >> `DHL_CFG_HR);
      r.compressor_rotation_point <= 4'(`DHL_CFG_RST >> `DHL_CFG_ROT);
      r.fixed_limiter_threshold   <= 4'(`DHL_CFG_RST >> `DHL_CFG_THR);
      // Bus idles ready with an OKAY answer
      r.wr_pend                   <= 1'b0;
      r.wr_addr                   <= 32'h0000_0000;
      r.rdata                     <= 32'h0000_0000;
      r.ready                     <= 1'b1;
      r.resp                      <= 1'b0;
      r.atpo                      <= 16'sh0000;
      r.ain                       <= 16'sh0000;
      r.atten                     <= 16'sh0000;
      r.active                    <= 1'b0;
      r.begin_ev                  <= 1'b0;
      r.end_ev                    <= 1'b0;
      r.sample                    <= 24'sh00_0000;
      r.valid                     <= 1'b0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign hrdata                  = r.rdata;
  assign hreadyout               = r.ready;
  assign hresp                   = r.resp;
  assign sample_out              = r.sample;
  assign sample_out_valid        = r.valid;
  assign attenuation_begin_event = r.begin_ev;
  assign attenuation_end_event   = r.end_ev;
  assign headroom_active         = r.active;

endmodule

// ---- verification/dhl_chk.sv ----
// Port assertions of the headroom limiter
module dhl_chk
(
  // Clock and reset
  input wire logic         hclk,
  input wire logic         hresetn,
  // Bus answer
  input wire logic         hreadyout,
  input wire logic         hresp,
  // Audio and events
  input dhl_pkg::dhl_smp_t sample_in,
  input wire logic         sample_in_valid,
  input dhl_pkg::dhl_smp_t sample_out,
  input wire logic         sample_out_valid,
  input wire logic         attenuation_begin_event,
  input wire logic         attenuation_end_event,
  input wire logic         headroom_active
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic [23:0] mag_in;
  logic [23:0] mag_out;
  assign mag_in = sample_in[23] ? 24'(-sample_in) : 24'(sample_in);
  assign mag_out = sample_out[23] ? 24'(-sample_out) : 24'(sample_out);

  sequence s_take; sample_in_valid; endsequence
  sequence s_give; sample_out_valid; endsequence
  sequence s_rise; $rose(headroom_active); endsequence

  property p_ready; hreadyout && !hresp; endproperty
  property p_answer; s_take |=> s_give; endproperty
  property p_quiet; !sample_in_valid |=> !sample_out_valid; endproperty
  property p_unity; s_give |-> mag_out <= $past(mag_in); endproperty
  property p_pass; s_give and !headroom_active |-> sample_out == $past(sample_in); endproperty
  property p_begin; s_rise |-> attenuation_begin_event; endproperty
  property p_end; $fell(headroom_active) |-> attenuation_end_event; endproperty
  property p_one; attenuation_begin_event |-> s_give and headroom_active && !attenuation_end_event; endproperty
  property p_hold; !sample_out_valid |-> $stable(sample_out) && $stable(headroom_active); endproperty

  a_ready: assert property (p_ready) else $error("bus not ready or error");
  a_answer: assert property (p_answer) else $error("no output one cycle after sample");
  a_quiet: assert property (p_quiet) else $error("output without sample");
  a_unity: assert property (p_unity) else $error("gain above unity");
  a_pass: assert property (p_pass) else $error("sample changed while inactive");
  a_begin: assert property (p_begin) else $error("no begin event");
  a_end: assert property (p_end) else $error("no end event");
  a_one: assert property (p_one) else $error("begin event out of place");
  a_hold: assert property (p_hold) else $error("output moved between samples");
endmodule

bind dhl_top dhl_chk i_dhl_chk (.hclk, .hresetn, .hreadyout, .hresp, .sample_in, .sample_in_valid, .sample_out,
  .sample_out_valid, .attenuation_begin_event, .attenuation_end_event, .headroom_active);

// ---- verification/dhl_adc_model.sv ----
// Supply measurement converter model for both rails
module dhl_adc_model
(
  // Clock and reset
  input wire logic   hclk,
  input wire logic   hresetn,
  // Levels to report, volts 8.8
  input wire logic [15:0] pwr_set,
  input wire logic [15:0] bat_set,
  input wire logic   use_pwr,
  input wire logic   slow,
  // Results
  output logic [15:0] power_rail_level,
  output logic [15:0] battery_rail_level,
  output logic       rail_is_power
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] tick;
  // Channels convert from reset on, before tracking is enabled
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      tick <= 3'h0;
      power_rail_level <= 16'h0000;
      battery_rail_level <= 16'h0000;
      rail_is_power <= 1'b0;
    end
    else
    begin
      tick <= tick + 3'h1;
      // Slow mode reports one conversion in eight cycles
      if (!slow || tick == 3'h0)
      begin
        power_rail_level <= pwr_set;
        battery_rail_level <= bat_set;
        rail_is_power <= use_pwr;
      end
    end
endmodule

// ---- verification/dhl_top_tb.sv ----
// Self-checking bench of the headroom limiter
`include "dhl_defines.svh"
module dhl_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, use_pwr, slow;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] pwr_set, bat_set, power_rail_level, battery_rail_level;
  logic rail_is_power, sample_in_valid, sample_out_valid;
  logic attenuation_begin_event, attenuation_end_event, headroom_active;
  dhl_pkg::dhl_smp_t sample_in, sample_out, y;
  int err_count, checked, seed, g, hr, s;
  real vs, a;
  assign hready = hreadyout;

  dhl_top i_dhl_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .power_rail_level, .battery_rail_level, .rail_is_power, .sample_in, .sample_in_valid,
    .sample_out, .sample_out_valid, .attenuation_begin_event, .attenuation_end_event, .headroom_active);
  dhl_adc_model i_dhl_adc_model (.hclk, .hresetn, .pwr_set, .bat_set, .use_pwr, .slow, .power_rail_level,
    .battery_rail_level, .rail_is_power);

  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task results;
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input bit ok, input string m);
    checked++;
    if (!ok)
    begin
      err_count++;
      $display("unexpected %0t: %s", $time, m);
    end
  endtask

  task ahb(input bit wr, input logic [31:0] ad, input logic [31:0] wd, input logic [2:0] sz);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= ad; hwrite <= wr; hsize <= sz;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  task cfg(input bit en, input bit kind, input int gc, input int h, input int rot, input int thr, input real v);
    bit sel;
    sel = 1'($random(seed));
    @(posedge hclk);
    use_pwr <= sel; slow <= 1'($random(seed));
    pwr_set <= sel ? 16'(int'(v * 256.0)) : 16'h0C00;
    bat_set <= sel ? 16'h0C00 : 16'(int'(v * 256.0));
    ahb(1'b1, `DHL_CFG_OFS, {15'h0000, 4'(thr), 4'(rot), 5'(h), 4'(gc)}, 3'h2);
    ahb(1'b1, `DHL_CTRL_OFS, {30'h0000_0000, kind, en}, 3'h2);
    // Let slow conversions and tracking settle
    repeat (20) @(posedge hclk);
  endtask

  task send(input int x);
    @(posedge hclk);
    sample_in <= 24'(x); sample_in_valid <= 1'b1;
    @(posedge hclk);
    sample_in_valid <= 1'b0;
    #1 y = sample_out;
  endtask

  function real tpo(real v, int h, int gc);
    real t;
    t = 20.0 * $log10(v * (1.0 - h * 0.025) / $pow(10.0, (7.68 + (gc > 12 ? 12 : gc)) / 20.0));
    return t > 0.0 ? 0.0 : t;
  endfunction

  function bit near(dhl_pkg::dhl_smp_t v, real db);
    real e, m;
    e = 8388608.0 * $pow(10.0, db / 20.0);
    m = (v < 0) ? -real'(v) : real'(v);
    return m > e * 0.87 && m < e * 1.15;
  endfunction

  // Level word against dB, 1/256 octave units
  function bit close(logic [15:0] v, real db, int tol);
    int e;
    e = int'(db * 256.0 / 6.0206);
    return $signed(v) >= e - tol && $signed(v) <= e + tol;
  endfunction

  initial
  begin
    seed = 39; hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = 32'h0; use_pwr = 1'b0; slow = 1'b0; pwr_set = 16'h0; bat_set = 16'h0; sample_in = 24'h0;
    sample_in_valid = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, `DHL_CTRL_OFS, 32'h0, 3'h2); chk(r === 32'h0, "ctrl reset");
    ahb(1'b0, 32'h0000_0010, 32'h0, 3'h2); chk(r === 32'h0, "unmapped read");
    ahb(1'b1, `DHL_CFG_OFS, 32'h0001_5A8C, 3'h0);
    ahb(1'b0, `DHL_CFG_OFS, 32'h0, 3'h2); chk(r === 32'h0, "byte write taken");
    ahb(1'b1, `DHL_CFG_OFS, 32'h0001_5A8C, 3'h2);
    ahb(1'b0, `DHL_CFG_OFS, 32'h0, 3'h2); chk(r === 32'h0001_5A8C, "cfg readback");
    // Tracking off at low supply
    cfg(1'b0, 1'b0, 0, 0, 0, 0, 1.0);
    repeat (8)
    begin
      s = $random(seed);
      send(s); chk(y === 24'(s), "bypass changed");
    end
    // Supply tracking limiter, corner cases first
    for (int i = 0; i < 10; i++)
    begin
      g = i == 0 ? 14 : {$random(seed)} % 15;
      hr = i == 0 ? 8 : i == 1 ? -8 : {$random(seed)} % 17 - 8;
      vs = i == 1 ? 9.0 : 1.0 + ({$random(seed)} % 600) / 100.0;
      a = tpo(vs, hr, g);
      cfg(1'b1, 1'b0, g, hr, 0, 0, vs);
      s = int'(8388608.0 * $pow(10.0, (a - 6.0) / 20.0));
      send(s); chk(y === 24'(s) && headroom_active === 1'b0, "below knee");
      send(-8388607); chk(near(y, a), "tracking peak");
      if (a < -1.5) chk(attenuation_begin_event === 1'b1 && headroom_active === 1'b1, "no begin");
      ahb(1'b0, `DHL_LEVEL_OFS, 32'h0, 3'h2);
      chk(close(r[31:16], a, 30) && close(r[15:0], 0.0, 3), "level word");
      send(-s); chk(y === 24'(-s) && (a >= -1.5 || attenuation_end_event === 1'b1), "release");
    end
    // Fixed limiter at low supply
    for (int t = 0; t < 16; t += 5)
    begin
      cfg(1'b1, 1'b1, 0, 0, 0, t, 1.0);
      send(8388607); chk(near(y, -t), "level peak");
      ahb(1'b0, `DHL_STAT_OFS, 32'h0, 3'h2);
      chk(close(r[31:16], -t, 12) && r[15:0] === {15'h0000, t > 0}, "status word");
      s = int'(8388608.0 * $pow(10.0, (-t - 6.0) / 20.0));
      send(s); chk(y === 24'(s), "below level");
    end
    // Compressor alone, then with the level limiter
    cfg(1'b1, 1'b1, 0, 0, 8, 0, 9.0);
    send(8388607); chk(near(y, -4.0), "compressor");
    cfg(1'b1, 1'b1, 0, 0, 4, 3, 9.0);
    send(8388607); chk(near(y, -3.0), "compressor and limiter");
    send(1000); chk(y === 24'(1000), "mode 4 release");
    cfg(1'b0, 1'b0, 0, 0, 0, 0, 9.0);
    results;
  end

  initial
  begin
    #200000;
    err_count++;
    results;
  end
endmodule
